// file: rtl/sdd_filter.sv
// sinc3 decimating filter rebuilding 16-bit words from the bit stream
`timescale 1ns/10ps
`default_nettype none
module sdd_filter
(
    input  wire logic                              CLOCK,
    input  wire logic                              NRST,
    sdd_link_if.filter                             LINK,
    output var  logic [sdd_pkg::WORD_W-1:0]        DATA_WORD,
    output var  logic                              WORD_VALID
);
    logic                               clk_s1;
    logic                               clk_s2;
    logic                               clk_s3;
    logic                               bit_s1;
    logic                               bit_s2;
    logic                               bit_prev;
    logic                               link_rise;
    logic [sdd_pkg::CNT_W-1:0]          word_count;
    logic                               word_tick;
    logic                               word_ready;
    logic [sdd_pkg::ACC_W-1:0]          acc1;
    logic [sdd_pkg::ACC_W-1:0]          acc2;
    logic [sdd_pkg::ACC_W-1:0]          acc3;
    logic [sdd_pkg::ACC_W-1:0]          acc3_d;
    logic [sdd_pkg::ACC_W-1:0]          diff1;
    logic [sdd_pkg::ACC_W-1:0]          diff1_d;
    logic [sdd_pkg::ACC_W-1:0]          diff2;
    logic [sdd_pkg::ACC_W-1:0]          diff2_d;
    logic [sdd_pkg::ACC_W-1:0]          diff3;

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; link pins are foreign to CLOCK
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            clk_s1   <= 1'b0;
            clk_s2   <= 1'b0;
            clk_s3   <= 1'b0;
            bit_s1   <= 1'b0;
            bit_s2   <= 1'b0;
            bit_prev <= 1'b0;
        end
        else
        begin
            clk_s1   <= LINK.modulator_clock_out;
            clk_s2   <= clk_s1;
            clk_s3   <= clk_s2;
            bit_s1   <= LINK.modulator_bit_out;
            bit_s2   <= bit_s1;
            bit_prev <= bit_s2;
        end
    end

    // the bit seen just before this rise is the one launched at the last rise
    assign link_rise = clk_s2 && !clk_s3; // RULE_03
    assign word_tick = link_rise && (word_count == sdd_pkg::CNT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // three integrators, one modulator bit per link clock
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            acc1 <= sdd_pkg::ACC_RESET; // RULE_12
            acc2 <= sdd_pkg::ACC_RESET;
            acc3 <= sdd_pkg::ACC_RESET;
        end
        else if (link_rise)
        begin
            // wrap-around is harmless: differences cancel it
            acc1 <= acc1 + {{(sdd_pkg::ACC_W-1){1'b0}}, bit_prev}; // RULE_08 RULE_12
            acc2 <= acc2 + acc1;
            acc3 <= acc3 + acc2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decimation counter
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            word_count <= sdd_pkg::CNT_RESET; // RULE_12
        else if (link_rise)
            word_count <= word_count + 8'h01; // RULE_09
    end

    ////////////////////////////////////////////////////////////////////////////
    // three differentiators at the word rate
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            acc3_d  <= sdd_pkg::ACC_RESET; // RULE_12
            diff1   <= sdd_pkg::ACC_RESET;
            diff1_d <= sdd_pkg::ACC_RESET;
            diff2   <= sdd_pkg::ACC_RESET;
            diff2_d <= sdd_pkg::ACC_RESET;
            diff3   <= sdd_pkg::ACC_RESET;
        end
        else if (word_tick)
        begin
            acc3_d  <= acc3;
            diff1   <= acc3 - acc3_d; // RULE_08
            diff1_d <= diff1;
            diff2   <= diff1 - diff1_d;
            diff2_d <= diff2;
            diff3   <= diff2 - diff2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output word: gain 256^3 = 2^24, top 16 bits give midscale 32768
    // at half density; an all-ones stream wraps to zero, as in the sinc
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            word_ready <= 1'b0;
            DATA_WORD  <= sdd_pkg::WORD_RESET;
            WORD_VALID <= 1'b0;
        end
        else
        begin
            word_ready <= word_tick;
            WORD_VALID <= word_ready;
            if (word_ready)
                DATA_WORD <= diff3[sdd_pkg::ACC_W-1 -: sdd_pkg::WORD_W]; // RULE_09 RULE_10 RULE_11
        end
    end
endmodule : sdd_filter
`default_nettype wire

// file: rtl/sdd_pkg.sv
// constants shared by the bitstream modulator and the decimating filter
//
// What this block does
// RULE_01: continuous 10 MHz bit stream, average tracks input
// RULE_02: one internal clock times conversion and framing
// RULE_03: bit launched on rise, valid next rise
// RULE_04: zero input gives half ones, half zeros
// RULE_05: plus 200/250 mV give 81.25%/89.06% ones
// RULE_06: minus 200/250 mV give 18.75%/10.94% ones
// RULE_07: plus 320 mV input gives all ones
// RULE_08: receiver uses third-order sinc, then decimates
// RULE_09: decimate by 256 to 16-bit words
// RULE_10: zero input lands on code 32768
// RULE_11: minus/plus 250 mV map to 7169/58366
// RULE_12: reset clears filter state, then integrate again
package sdd_pkg;
    // system clock and modulator clock rates
    localparam int CLK_HZ       = 100_000_000;
    localparam int MOD_CLK_HZ   = 10_000_000;
    // system clock cycles per half period of the modulator clock
    localparam int DIV_HALF     = CLK_HZ / MOD_CLK_HZ / 2;
    localparam int DIV_W        = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_HALF - 1);
    localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

    // analog input scale in millivolts
    localparam int IN_W         = 11;
    localparam int FULL_SCALE_MV = 320;
    localparam logic signed [IN_W-1:0] IN_POS_FS = IN_W'(FULL_SCALE_MV);
    localparam logic signed [IN_W-1:0] IN_NEG_FS = IN_W'(-FULL_SCALE_MV);

    // modulator integrator width
    localparam int MOD_W        = 16;
    localparam logic signed [MOD_W-1:0] MOD_RESET = 16'h0000;

    // filter geometry
    localparam int DECIMATION   = 256;
    localparam int CNT_W        = 8;
    localparam int ACC_W        = 24;
    localparam int WORD_W       = 16;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DECIMATION - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    // code anchors of the transfer characteristic
    localparam logic [WORD_W-1:0] CODE_MID    = 16'h8000;
    localparam logic [WORD_W-1:0] CODE_NEG_FS = 16'h1C01;
    localparam logic [WORD_W-1:0] CODE_POS_FS = 16'hE3FE;
endpackage : sdd_pkg

// file: rtl/sdd_link_if.sv
// link between the modulator and the decimation filter
`timescale 1ns/10ps
`default_nettype none
interface sdd_link_if;
    logic modulator_bit_out;
    logic modulator_clock_out;

    modport modulator
    (
        output modulator_bit_out,
        output modulator_clock_out
    );

    modport filter
    (
        input modulator_bit_out,
        input modulator_clock_out
    );
endinterface : sdd_link_if
`default_nettype wire

// file: rtl/sdd_modulator.sv
// second-order bitstream modulator with its own divided sample clock
`timescale 1ns/10ps
`default_nettype none
module sdd_modulator
(
    input  wire logic                             CLOCK,
    input  wire logic                             NRST,
    input  wire logic signed [sdd_pkg::IN_W-1:0]  DIFF_MV,
    sdd_link_if.modulator                         LINK
);
    // loop width, and two guard bits so a sum can be clipped, not wrapped
    localparam int                      LOOP_W  = sdd_pkg::MOD_W;
    localparam int                      SUM_W   = LOOP_W + 2;
    localparam logic signed [SUM_W-1:0] SUM_MAX = SUM_W'((2 ** (LOOP_W - 1)) - 1);
    localparam logic signed [SUM_W-1:0] SUM_MIN = SUM_W'(-(2 ** (LOOP_W - 1)));

    logic [sdd_pkg::DIV_W-1:0]          div_count;
    logic                               mod_clk;
    logic                               mod_bit;
    logic signed [sdd_pkg::MOD_W-1:0]   integ1;
    logic signed [sdd_pkg::MOD_W-1:0]   integ2;
    logic signed [sdd_pkg::MOD_W-1:0]   x_in;
    logic signed [sdd_pkg::MOD_W-1:0]   feedback;
    logic signed [sdd_pkg::MOD_W-1:0]   next_integ1;
    logic signed [sdd_pkg::MOD_W-1:0]   next_integ2;
    logic                               rise_now;
    logic signed [SUM_W-1:0]            sum1;
    logic signed [SUM_W-1:0]            sum2;

    // clip a widened loop sum back into the integrator range
    function automatic logic signed [LOOP_W-1:0] clip
    (
        input logic signed [SUM_W-1:0] sum
    );
        if (sum > SUM_MAX)
            return LOOP_W'(SUM_MAX);
        else if (sum < SUM_MIN)
            return LOOP_W'(SUM_MIN);
        else
            return LOOP_W'(sum);
    endfunction : clip

    ////////////////////////////////////////////////////////////////////////////
    // sample clock divider, the only timebase of the conversion
    assign rise_now = (div_count == sdd_pkg::DIV_LAST) && !mod_clk;

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            div_count <= sdd_pkg::DIV_RESET;
            mod_clk   <= 1'b0;
        end
        else if (div_count == sdd_pkg::DIV_LAST)
        begin
            div_count <= sdd_pkg::DIV_RESET;
            mod_clk   <= !mod_clk; // RULE_02
        end
        else
        begin
            div_count <= div_count + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input clamp and loop arithmetic; feedback equals full scale so
    // density of ones = (x + 320) / 640
    always_comb
    begin
        if (DIFF_MV > sdd_pkg::IN_POS_FS)
            x_in = LOOP_W'(sdd_pkg::IN_POS_FS);
        else if (DIFF_MV < sdd_pkg::IN_NEG_FS)
            x_in = LOOP_W'(sdd_pkg::IN_NEG_FS);
        else
            x_in = LOOP_W'(DIFF_MV);
        if (mod_bit)
            feedback = LOOP_W'(sdd_pkg::IN_POS_FS);
        else
            feedback = LOOP_W'(sdd_pkg::IN_NEG_FS);
        // clipping, not wrapping: a pinned loop at +320 mV parks the second
        // integrator at its top, so the stream stays all ones
        sum1        = SUM_W'(integ1) + SUM_W'(x_in) - SUM_W'(feedback);
        next_integ1 = clip(sum1); // RULE_04 RULE_05 RULE_06
        sum2        = SUM_W'(integ2) + SUM_W'(next_integ1) - SUM_W'(feedback);
        next_integ2 = clip(sum2); // RULE_07
    end

    ////////////////////////////////////////////////////////////////////////////
    // loop state and bit launched together with the clock rise
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            integ1  <= sdd_pkg::MOD_RESET;
            integ2  <= sdd_pkg::MOD_RESET;
            mod_bit <= 1'b0;
        end
        else if (rise_now)
        begin
            integ1  <= next_integ1;
            integ2  <= next_integ2;
            // at +320 mV the loop pins high: all ones
            mod_bit <= (next_integ2 >= 0); // RULE_01 RULE_03 RULE_07
        end
    end

    // both link pins straight from flip-flops
    assign LINK.modulator_bit_out   = mod_bit;
    assign LINK.modulator_clock_out = mod_clk;
endmodule : sdd_modulator
`default_nettype wire

// file: test/sdd_link_props.sv
// concurrent checks on the link and the filter word output
`timescale 1ns/10ps
`default_nettype none
module sdd_link_props
(
    input wire logic                       CLOCK,
    input wire logic                       NRST,
    input wire logic                       modulator_bit_out,
    input wire logic                       modulator_clock_out,
    input wire logic [sdd_pkg::WORD_W-1:0] DATA_WORD,
    input wire logic                       WORD_VALID
);
    logic [11:0] gap;
    logic [8:0]  rises;
    logic        seen;
    logic        clk_q;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////
    // gap and rise counts between words; first word has no reference
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            clk_q <= 1'b0;
            gap   <= 12'h000;
            rises <= 9'h000;
            seen  <= 1'b0;
        end
        else
        begin
            clk_q <= modulator_clock_out;
            gap   <= WORD_VALID ? 12'h000 : gap + 12'h001;
            rises <= (WORD_VALID ? 9'h000 : rises) + 9'(modulator_clock_out & ~clk_q);
            seen  <= seen | WORD_VALID;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence high_phase;
        modulator_clock_out [*5] ##1 !modulator_clock_out;
    endsequence
    sequence low_phase;
        !modulator_clock_out [*5] ##1 modulator_clock_out;
    endsequence
    a_clk_high_phase: assert property ($rose(modulator_clock_out) |-> high_phase)
        else $error("link clock high phase not five cycles");
    a_clk_low_phase: assert property ($fell(modulator_clock_out) |-> low_phase)
        else $error("link clock low phase not five cycles");
    a_bit_at_rise: assert property ($changed(modulator_bit_out) |-> $rose(modulator_clock_out))
        else $error("bit changed away from a link clock rise");
    a_bit_holds: assert property ($rose(modulator_clock_out) |=> $stable(modulator_bit_out) [*8])
        else $error("bit did not hold through the link period");
    a_valid_one_cycle: assert property (WORD_VALID |=> !WORD_VALID)
        else $error("word valid longer than one cycle");
    a_word_holds: assert property (!WORD_VALID |-> $stable(DATA_WORD))
        else $error("word changed without valid");
    a_word_spacing: assert property (WORD_VALID && seen |-> gap == 12'h9FF)
        else $error("words not 2560 cycles apart");
    a_word_rises: assert property (WORD_VALID && seen |-> rises == 9'h100)
        else $error("word not after 256 link bits");
endmodule : sdd_link_props
`default_nettype wire

// file: test/sigma_delta_bitstream_decimator_bench.sv
// bench joining modulator and filter, checking stream density and words
`timescale 1ns/10ps
`default_nettype none
module sigma_delta_bitstream_decimator_bench;
    logic                            clk;
    logic                            nrst;
    logic signed [sdd_pkg::IN_W-1:0] diff_mv;
    logic [sdd_pkg::WORD_W-1:0]      data_word;
    logic                            word_valid;
    int                              n_fail;
    int                              checked;
    int                              mv;
    sdd_link_if link ();
    sdd_modulator sdd_modulator_inst (.CLOCK(clk), .NRST(nrst), .DIFF_MV(diff_mv), .LINK(link));
    sdd_filter sdd_filter_inst (.CLOCK(clk), .NRST(nrst), .LINK(link),
        .DATA_WORD(data_word), .WORD_VALID(word_valid));
    sdd_link_props sdd_link_props_inst (.CLOCK(clk), .NRST(nrst),
        .modulator_bit_out(link.modulator_bit_out),
        .modulator_clock_out(link.modulator_clock_out),
        .DATA_WORD(data_word), .WORD_VALID(word_valid));
    ////////////////////////////////////////////////////////////////
    // compare with tolerance; stream averages carry loop noise
    task automatic check(input string what, input int exp, input logic [15:0] got, input int tol);
        int d;
        d = int'(got) - exp;
        checked++;
        if ((^got === 1'bx) || d > tol || d < -tol)
        begin
            n_fail++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    // count ones consumed at 256 link rises after 16 settling bits
    task automatic density(input int exp);
        logic [15:0] ones;
        logic        pclk;
        logic        pbit;
        int          n;
        ones = 16'h0000;
        pclk = 1'b1;
        pbit = 1'b0;
        n = 0;
        while (n < 272)
        begin
            @(posedge clk);
            #1;
            if (link.modulator_clock_out && !pclk)
            begin
                n++;
                if (n > 16)
                    ones = ones + 16'(pbit);
            end
            pclk = link.modulator_clock_out;
            pbit = link.modulator_bit_out;
        end
        check("ones", exp, ones, 3);
    endtask : density
    task automatic wait_valid();
        int k;
        @(posedge clk);
        #1;
        for (k = 0; k < 3000 && word_valid !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        if (word_valid !== 1'b1)
        begin
            n_fail++;
            $display("[ERR] word_valid expected 1 seen %0b", word_valid);
        end
    endtask : wait_valid
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard: 35 words of 2560 cycles expected, a margin on top
    initial
    begin
        repeat (98000) @(posedge clk);
        n_fail++;
        finish_test();
    end
    initial
    begin
        n_fail = 0;
        checked = 0;
        nrst = 1'b0;
        diff_mv = 11'h000;
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            mv = (i == 0) ? 0 : (i == 1) ? 200 : (i == 2) ? 250 : (i == 3) ? -200 : (i == 4) ? -250 : 320;
            diff_mv = 11'(mv);
            // step lands just after a word, so the fifth word's sinc window
            // spans the new input only; density runs alongside
            fork
                density((mv + 320) * 2 / 5);
                repeat (5) wait_valid();
            join
            if (mv == 0)
                check("mid", int'(sdd_pkg::CODE_MID), data_word, 16);
            else if (mv == 250 || mv == -250)
                check("fs", int'(mv > 0 ? sdd_pkg::CODE_POS_FS : sdd_pkg::CODE_NEG_FS), data_word, 16);
            else if (mv != 320)
                check("word", (mv + 320) * 1024 / 10, data_word, 16);
            $display("test %0d at %0d mV done", i, mv);
        end
        // reset in mid-run, then the filter restarts from clear state
        @(posedge clk);
        #1 nrst = 1'b0;
        diff_mv = 11'h000;
        #20;
        check("reset word", 0, data_word, 0);
        check("reset link", 0, {13'h0000, link.modulator_bit_out, link.modulator_clock_out, word_valid}, 0);
        @(posedge clk);
        #1 nrst = 1'b1;
        repeat (5) wait_valid();
        check("restart", int'(sdd_pkg::CODE_MID), data_word, 16);
        $display("test reset done");
        finish_test();
    end
endmodule : sigma_delta_bitstream_decimator_bench
`default_nettype wire
